// ### hw/return_stack_pkg.sv
// Purpose: Shared constants for the circular return-address stack
// Assumes: One clock, synchronous active-high reset
// Notes: Widths and depth are fixed, not parameters
`default_nettype none
package return_stack_pkg;
  // ==========================================================
  // Geometry
  localparam int unsigned DEPTH = 16;
  localparam int unsigned PTR_W = 4;
  localparam int unsigned DATA_W = 16;
  // ==========================================================
  // Reset values and pointer landmarks
  localparam logic [3:0] PTR_RESET = 4'h0;
  localparam logic [3:0] PTR_TOP = 4'hF;
  localparam logic [3:0] PTR_STEP = 4'h1;
  localparam logic FLAG_RESET = 1'b1;
  localparam logic LOCK_RESET = 1'b0;
  localparam logic [15:0] DATA_RESET = 16'h0000;
  // ==========================================================
  // CPU status byte layout
  localparam int unsigned STATUS_W = 8;
  localparam int unsigned STATUS_FLAG_BIT = 5;
  localparam logic [7:0] STATUS_RESET = 8'h00;
endpackage
`default_nettype wire

// ### hw/stack_mem_if.sv
// Purpose: Carrier between stack control and its entry storage
// Assumes: Single clock domain
// Notes: Read data returns one cycle after the read strobe
`default_nettype none
interface stack_mem_if;
  logic wr_en;
  logic [3:0] wr_addr;
  logic [15:0] wr_data;
  logic rd_en;
  logic [3:0] rd_addr;
  logic [15:0] rd_data;
  // ==========================================================
  // Control side drives strobes, storage side returns data
  modport ctrl (
    output wr_en, wr_addr, wr_data, rd_en, rd_addr,
    input rd_data
  );
  modport mem (
    input wr_en, wr_addr, wr_data, rd_en, rd_addr,
    output rd_data
  );
endinterface
`default_nettype wire

// ### hw/stack_entries.sv
// Purpose: Sixteen by sixteen entry storage with registered read
// Assumes: Controller never reads and writes the same cycle
// Notes: Entries are cleared by reset for determinism only
`default_nettype none
module stack_entries (
  input wire logic clk,
  input wire logic reset,
  stack_mem_if.mem port
);
  typedef struct packed {
    logic [15:0][15:0] entries;
    logic [15:0] rd_data;
  } mem_state_type;

  mem_state_type state;
  mem_state_type next_state;

  // ==========================================================
  // Storage update
  // Write lands in the slot the pointer names; read is registered
  always_comb begin
    next_state = state;
    if (port.wr_en) begin
      next_state.entries[port.wr_addr] = port.wr_data;
    end
    if (port.rd_en) begin
      next_state.rd_data = state.entries[port.rd_addr];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign port.rd_data = state.rd_data;
endmodule
`default_nettype wire

// ### hw/circular_return_stack.sv
// Purpose: Hidden circular return-address stack with space flag
// Assumes: Sequencer gives one-cycle push and pop strobes
// Notes: Push wins when push and pop arrive together
`default_nettype none
module circular_return_stack (
  input wire logic clk,
  input wire logic reset,
  input wire logic push,
  input wire logic [15:0] push_data,
  input wire logic pop,
  output logic [15:0] pop_data,
  output logic pop_valid,
  output logic stack_space_flag,
  output logic [7:0] status_flag_byte
);
  typedef struct packed {
    logic [3:0] ptr;
    logic lock;
    logic pop_valid;
  } ctrl_state_type;

  ctrl_state_type state;
  ctrl_state_type next_state;
  logic do_push;
  logic do_pop;

  stack_mem_if mem_bus ();

  stack_entries entries_u (
    .clk(clk),
    .reset(reset),
    .port(mem_bus.mem)
  );

  // ==========================================================
  // Event qualification
  // A collision is resolved toward push so a call is never lost
  assign do_push = push;
  assign do_pop = pop && !push;

  // ==========================================================
  // Pointer and lock update
  // No port reaches the pointer, so software can neither see nor
  // move it; the lock latch lives here and is set by a push at pointer 15
  always_comb begin
    next_state = state;
    next_state.pop_valid = do_pop;
    if (do_push) begin
      next_state.ptr = 4'(state.ptr + return_stack_pkg::PTR_STEP);
      if (state.ptr == return_stack_pkg::PTR_TOP) begin
        next_state.lock = 1'b1;
      end
    end else if (do_pop) begin
      next_state.ptr = 4'(state.ptr - return_stack_pkg::PTR_STEP);
    end
  end

  // Reset is the only way to release the lock
  always_ff @(posedge clk) begin
    if (reset) begin
      state.ptr <= return_stack_pkg::PTR_RESET;
      state.lock <= return_stack_pkg::LOCK_RESET;
      state.pop_valid <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================
  // Storage strobes
  // Push writes the free slot, pop reads the most recent one;
  // overwrite of the oldest entry falls out of the modulo pointer
  assign mem_bus.wr_en = do_push;
  assign mem_bus.wr_addr = state.ptr;
  assign mem_bus.wr_data = push_data;
  assign mem_bus.rd_en = do_pop;
  assign mem_bus.rd_addr = 4'(state.ptr - return_stack_pkg::PTR_STEP);

  // ==========================================================
  // Outputs
  // Flag is derived, with no write path, so status writes are inert
  assign stack_space_flag = !state.lock &&
    (state.ptr != return_stack_pkg::PTR_TOP);
  always_comb begin
    status_flag_byte = return_stack_pkg::STATUS_RESET;
    status_flag_byte[return_stack_pkg::STATUS_FLAG_BIT] =
      stack_space_flag;
  end
  assign pop_data = mem_bus.rd_data;
  assign pop_valid = state.pop_valid;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  reset_state_a: assert property (
    @(posedge clk) disable iff (1'b0)
    reset |=> (state.ptr == 4'h0) && stack_space_flag)
    else $error("pointer or flag wrong after reset");
  reset_flag_a: assert property (
    @(posedge clk) disable iff (1'b0)
    reset ##1 !reset |-> stack_space_flag)
    else $error("space flag not set by reset");
  push_step_a: assert property (
    push |=> state.ptr == 4'($past(state.ptr) + 4'h1))
    else $error("push did not advance pointer by one");
  pop_step_a: assert property (
    pop && !push |=> state.ptr == 4'($past(state.ptr) - 4'h1)
      && pop_valid)
    else $error("pop did not retreat pointer by one");
  idle_hold_a: assert property (
    !push && !pop |=> $stable(state.ptr) && !pop_valid)
    else $error("pointer moved without an event");
  top_flag_a: assert property (
    state.ptr == 4'hF |-> !stack_space_flag)
    else $error("flag set while pointer at top");
  wrap_lock_a: assert property (
    push && state.ptr == 4'hF |=> !stack_space_flag [*3])
    else $error("flag not held clear after wrap");
  underflow_a: assert property (
    pop && !push && state.ptr == 4'h0 |=>
      state.ptr == 4'hF && !stack_space_flag)
    else $error("underflow pop did not look full");
  underflow_lock_a: assert property (
    pop && !push && state.ptr == 4'h0 ##1 (!push && !pop) ##1 push |=>
      !stack_space_flag ##1 !stack_space_flag)
    else $error("push after underflow did not lock flag");
  lifo_data_a: assert property (
    push ##1 (!push && !pop) ##1 (pop && !push) |=>
      pop_data == $past(push_data, 3))
    else $error("pop did not return last pushed value");
  status_bit_a: assert property (
    status_flag_byte == {2'b00, stack_space_flag, 5'b00000})
    else $error("status byte layout wrong");

  wrap_c: cover property (push && state.ptr == 4'hF);
  underflow_c: cover property (pop && !push && state.ptr == 4'h0);
  collide_c: cover property (push && pop);
  call_return_c: cover property (push ##1 pop ##1 pop_valid);
endmodule
`default_nettype wire

// ### verif/call_sequencer.sv
// Purpose: Sequencer model issuing calls and returns
// Assumes: Strobes move 1 ns after the rising edge
// Notes: One event per two cycles; collide drives push and pop together
`default_nettype none
module call_sequencer (
  input wire logic clk,
  output logic push,
  output logic [15:0] push_data,
  output logic pop
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // Strobes
  initial begin
    push = 1'b0;
    pop = 1'b0;
    push_data = 16'h0000;
  end
  // Call or interrupt entry hands over the return address
  task automatic call(input logic [15:0] pc);
    @(posedge clk);
    #1 push = 1'b1;
    push_data = pc;
    @(posedge clk);
    #1 push = 1'b0;
    push_data = ~pc; // Stale address must not look valid
  endtask
  // Call and return in one cycle: the return must be dropped
  task automatic collide(input logic [15:0] pc);
    @(posedge clk);
    #1 push = 1'b1;
    pop = 1'b1;
    push_data = pc;
    @(posedge clk);
    #1 push = 1'b0;
    pop = 1'b0;
    push_data = ~pc;
  endtask
  // Return: answer is registered, seen after the taking edge
  task automatic ret();
    @(posedge clk);
    #1 pop = 1'b1;
    @(posedge clk);
    #1 pop = 1'b0;
  endtask
endmodule
`default_nettype wire

// ### verif/testbench.sv
// Purpose: Self-checking bench for the circular return stack
// Assumes: Sync reset, 50 MHz clock
// Notes: Expected entries follow from push order and wrap
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic push, pop, pop_valid, stack_space_flag;
  logic [15:0] push_data, pop_data;
  logic [7:0] status_flag_byte;
  int failures = 0;
  int checks_done = 0;
  // ==========================================================
  // Clock and instances
  always #10 clk = ~clk;
  call_sequencer seq (.clk, .push, .push_data, .pop);
  circular_return_stack dut (.clk, .reset, .push, .push_data, .pop,
    .pop_data, .pop_valid, .stack_space_flag, .status_flag_byte);
  task automatic check(input string what, input logic [15:0] e,
    input logic [15:0] s);
    checks_done++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic end_of_test();
    if (failures == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic do_reset();
    @(posedge clk);
    #1 reset = 1'b1;
    repeat (2) @(posedge clk);
    #1 reset = 1'b0;
  endtask
  task automatic flag(input logic e);
    check("stack_space_flag", {15'h0000, e}, {15'h0000, stack_space_flag});
  endtask
  // Pop and judge in the single cycle that pop_valid stands
  task automatic pop_expect(input logic [15:0] e);
    seq.ret();
    check("pop_valid", 16'h0001, {15'h0000, pop_valid});
    check("pop_data", e, pop_data);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset();
    do_reset();
    flag(1'b1);
    check("status", 16'h0020, {8'h00, status_flag_byte});
    check("pop_valid", 16'h0000, {15'h0000, pop_valid});
  endtask
  // Flag falls only at fifteen; an unlocked pop raises it again
  task automatic t_fill();
    do_reset();
    for (int i = 0; i < 15; i++) begin
      seq.call(16'hA000 + 16'(i));
      flag(i != 14);
    end
    pop_expect(16'hA00E);
    flag(1'b1);
    seq.call(16'hA00E);
    seq.call(16'hA00F);
    pop_expect(16'hA00F);
    pop_expect(16'hA00E);
    flag(1'b0);
    check("status", 16'h0000, {8'h00, status_flag_byte});
  endtask
  // Eighteen pushes: the two newest overwrite the two oldest
  task automatic t_overwrite();
    do_reset();
    for (int i = 0; i < 18; i++) seq.call(16'h5000 + 16'(i));
    for (int i = 17; i >= 2; i--) pop_expect(16'h5000 + 16'(i));
    flag(1'b0);
  endtask
  // Pop before any push looks full; a push then locks the flag
  task automatic t_underflow();
    do_reset();
    seq.ret();
    flag(1'b0);
    seq.call(16'hC0DE);
    flag(1'b0);
    pop_expect(16'hC0DE);
    seq.ret();
    flag(1'b0);
    do_reset();
    flag(1'b1);
  endtask
  // Push and pop together: push wins, pointer moves once
  task automatic t_collide();
    do_reset();
    seq.collide(16'h3C3C);
    check("pop_valid", 16'h0000, {15'h0000, pop_valid});
    flag(1'b1);
    pop_expect(16'h3C3C);
    flag(1'b1);
  endtask
  initial begin
    t_reset();
    t_collide();
    t_fill();
    t_overwrite();
    t_underflow();
    end_of_test();
  end
endmodule
`default_nettype wire
